// ===== rtl/gpe_pkg.sv
// Register map, field constants and reset values of the edge-wake GPIO block
package gpe_pkg;
  // Data and address widths of the register port
  localparam int GPE_DW = 32;
  localparam int GPE_AW = 12;
  // Address pages, selected by address bits 11:8
  localparam logic [3:0] GPE_PAGE_PORT = 4'h0;
  localparam logic [3:0] GPE_PAGE_LEGACY = 4'h1;
  localparam logic [3:0] GPE_PAGE_EDGE = 4'h2;
  // Fast port registers, port n at 0x000 + n*0x20
  localparam logic [4:0] GPE_OFS_DIR = 5'h00;
  localparam logic [4:0] GPE_OFS_MASK = 5'h04;
  localparam logic [4:0] GPE_OFS_PIN = 5'h08;
  localparam logic [4:0] GPE_OFS_SET = 5'h0C;
  localparam logic [4:0] GPE_OFS_CLR = 5'h10;
  // Legacy copies of first and second port, port n at 0x100 + n*0x10
  localparam logic [3:0] GPE_LOFS_PIN = 4'h0;
  localparam logic [3:0] GPE_LOFS_SET = 4'h4;
  localparam logic [3:0] GPE_LOFS_DIR = 4'h8;
  localparam logic [3:0] GPE_LOFS_CLR = 4'hC;
  // Edge interrupt registers, bank k at 0x200 + k*0x20
  localparam logic [4:0] GPE_EOFS_RISE = 5'h00;
  localparam logic [4:0] GPE_EOFS_FALL = 5'h04;
  localparam logic [4:0] GPE_EOFS_STAT = 5'h08;
  localparam logic [4:0] GPE_EOFS_MASK = 5'h0C;
  // Ports that own an edge bank: first_port and third_port
  localparam int GPE_EDGE_BANKS = 2;
  localparam int GPE_EDGE_FIRST_PORT = 0;
  localparam int GPE_EDGE_SECOND_PORT = 2;
  localparam int GPE_LEGACY_PORTS = 2;
  // Reset values
  localparam logic [31:0] GPE_RST_DIR = 32'h0000_0000;
  localparam logic [31:0] GPE_RST_LAT = 32'h0000_0000;
  localparam logic [31:0] GPE_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] GPE_RST_EDGE = 32'h0000_0000;
  localparam logic [31:0] GPE_RD_NONE = 32'h0000_0000;
endpackage

// ===== rtl/gpe_top.sv
// Edge-wake GPIO block: direction, latch, mask, set/clear, legacy copies, edge interrupts
//
// Contract
// R1 - Pins not taken by a peripheral are driven and sampled by these registers.
// R2 - Every pin has its own direction bit, changeable at any time.
// R3 - Ones written to set drive outputs high, to clear drive them low.
// R4 - Output latch and live pin level are both readable.
// R5 - Mask bits keep outputs unchanged on port writes.
// R6 - Byte and halfword accesses touch only the addressed lanes.
// R7 - Whole port value is written in one full access.
// R8 - First and third port pins raise interrupts on rising, falling or both edges.
// R9 - Edge detection works without a running clock.
// R10 - Any enabled pin edge can wake the chip from power-down.
// R11 - After reset all pins are inputs.
// R12 - First and second port are also reachable through legacy register copies.
// R13 - Edge requests merge with the fourth external interrupt line.
// R14 - Edges set sticky pending bits, cleared by writing one; request holds meanwhile.
`timescale 1ns/10ps
module gpe_top #(
  parameter int NP = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [gpe_pkg::GPE_AW-1:0] bus_addr,
  input wire logic [gpe_pkg::GPE_DW-1:0] bus_wdata,
  input wire logic [3:0] bus_be,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [gpe_pkg::GPE_DW-1:0] bus_rdata,
  input wire logic [NP-1:0][gpe_pkg::GPE_DW-1:0] pin_in,
  output logic [NP-1:0][gpe_pkg::GPE_DW-1:0] pin_out,
  output logic [NP-1:0][gpe_pkg::GPE_DW-1:0] pin_oe,
  input wire logic [NP-1:0][gpe_pkg::GPE_DW-1:0] periph_sel,
  input wire logic fourth_external_irq_line,
  output logic irq,
  output logic wake_req
);
  import gpe_pkg::*;

  // Port index is three address bits and the third port must exist
  if (NP < 3 || NP > 8) begin : g_np_check
    $error("gpe_top: NP must lie between 3 and 8");
  end

  typedef logic [GPE_DW-1:0] gpe_word_t;

  // Reset release through two flops
  logic rst_s1, rst_n_sync;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_sync <= rst_s1;
    end
  end

  // Pin and external line synchronisers, plus one stage of history for edges
  gpe_word_t [NP-1:0] pin_s1, pin_s2, pin_prev;
  logic ext_s1, ext_s2;
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_prev <= '0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
      ext_s1 <= fourth_external_irq_line;
      ext_s2 <= ext_s1;
    end
  end

  // Expand byte enables to a bit mask
  function automatic gpe_word_t lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Address decode
  logic [3:0] page, l_reg;
  logic [2:0] p_idx;
  logic [4:0] p_reg;
  logic [1:0] l_idx, e_idx;
  gpe_word_t bemask;
  assign page = bus_addr[11:8];
  assign p_idx = bus_addr[7:5];
  assign p_reg = bus_addr[4:0];
  assign l_idx = bus_addr[5:4];
  assign l_reg = bus_addr[3:0];
  assign e_idx = bus_addr[6:5];
  assign bemask = lanes(bus_be);

  // Register state
  gpe_word_t [NP-1:0] dir, lat, msk;
  gpe_word_t [GPE_EDGE_BANKS-1:0] rise_en, fall_en, pend, imask;
  gpe_word_t [NP-1:0] next_dir, next_lat, next_msk;
  gpe_word_t [GPE_EDGE_BANKS-1:0] next_rise, next_fall, next_pend, next_imask;
  gpe_word_t [GPE_EDGE_BANKS-1:0] edge_ev, edge_pin, edge_old;

  // Synchronised pin levels of the two edge ports
  assign edge_pin[0] = pin_s2[GPE_EDGE_FIRST_PORT];
  assign edge_pin[1] = pin_s2[GPE_EDGE_SECOND_PORT];
  assign edge_old[0] = pin_prev[GPE_EDGE_FIRST_PORT];
  assign edge_old[1] = pin_prev[GPE_EDGE_SECOND_PORT];

  // Enabled edges per bank; both enables give both edges
  always_comb begin
    for (int k = 0; k < GPE_EDGE_BANKS; k++) begin
      edge_ev[k] = (rise_en[k] & edge_pin[k] & ~edge_old[k])
                 | (fall_en[k] & ~edge_pin[k] & edge_old[k]); // R8
    end
  end

  // Next register values from bus writes and pin edges
  always_comb begin
    gpe_word_t keep;
    keep = '0;
    next_dir = dir;
    next_lat = lat;
    next_msk = msk;
    next_rise = rise_en;
    next_fall = fall_en;
    next_imask = imask;
    next_pend = pend;
    // Fast port registers; mask only guards the latch
    for (int p = 0; p < NP; p++) begin
      if (bus_wr && page == GPE_PAGE_PORT && p_idx == p[2:0]) begin
        keep = msk[p] | ~bemask; // R5 R6
        case (p_reg)
          GPE_OFS_DIR: next_dir[p] = (dir[p] & ~bemask) | (bus_wdata & bemask); // R2 R6
          GPE_OFS_MASK: next_msk[p] = (msk[p] & ~bemask) | (bus_wdata & bemask); // R6
          GPE_OFS_PIN: next_lat[p] = (lat[p] & keep) | (bus_wdata & ~keep); // R5 R7
          GPE_OFS_SET: next_lat[p] = lat[p] | (bus_wdata & ~keep); // R3
          GPE_OFS_CLR: next_lat[p] = lat[p] & ~(bus_wdata & ~keep); // R3
          default: keep = '0;
        endcase
      end
    end
    // Legacy copies share the same state but ignore the mask
    for (int p = 0; p < GPE_LEGACY_PORTS; p++) begin
      if (bus_wr && page == GPE_PAGE_LEGACY && l_idx == p[1:0]) begin
        case (l_reg)
          GPE_LOFS_PIN: next_lat[p] = (lat[p] & ~bemask) | (bus_wdata & bemask); // R12
          GPE_LOFS_SET: next_lat[p] = lat[p] | (bus_wdata & bemask); // R12
          GPE_LOFS_DIR: next_dir[p] = (dir[p] & ~bemask) | (bus_wdata & bemask); // R12
          GPE_LOFS_CLR: next_lat[p] = lat[p] & ~(bus_wdata & bemask); // R12
          default: keep = '0;
        endcase
      end
    end
    // Edge banks; a fresh edge beats a clear in the same cycle
    for (int k = 0; k < GPE_EDGE_BANKS; k++) begin
      if (bus_wr && page == GPE_PAGE_EDGE && e_idx == k[1:0]) begin
        case (p_reg)
          GPE_EOFS_RISE: next_rise[k] = (rise_en[k] & ~bemask) | (bus_wdata & bemask);
          GPE_EOFS_FALL: next_fall[k] = (fall_en[k] & ~bemask) | (bus_wdata & bemask);
          GPE_EOFS_STAT: next_pend[k] = pend[k] & ~(bus_wdata & bemask); // R14
          GPE_EOFS_MASK: next_imask[k] = (imask[k] & ~bemask) | (bus_wdata & bemask);
          default: keep = '0;
        endcase
      end
      next_pend[k] = next_pend[k] | edge_ev[k]; // R14
    end
  end

  // Register update; all pins come up as inputs
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      dir <= {NP{GPE_RST_DIR}}; // R11
      lat <= {NP{GPE_RST_LAT}};
      msk <= {NP{GPE_RST_MASK}};
      rise_en <= {GPE_EDGE_BANKS{GPE_RST_EDGE}};
      fall_en <= {GPE_EDGE_BANKS{GPE_RST_EDGE}};
      pend <= {GPE_EDGE_BANKS{GPE_RST_EDGE}};
      imask <= {GPE_EDGE_BANKS{GPE_RST_EDGE}};
    end else begin
      dir <= next_dir;
      lat <= next_lat;
      msk <= next_msk;
      rise_en <= next_rise;
      fall_en <= next_fall;
      pend <= next_pend;
      imask <= next_imask;
    end
  end

  // Read mux; unmapped addresses and write-only registers return zero
  gpe_word_t next_rdata;
  always_comb begin
    next_rdata = GPE_RD_NONE;
    if (bus_rd) begin
      for (int p = 0; p < NP; p++) begin
        if (page == GPE_PAGE_PORT && p_idx == p[2:0]) begin
          case (p_reg)
            GPE_OFS_DIR: next_rdata = dir[p];
            GPE_OFS_MASK: next_rdata = msk[p];
            GPE_OFS_PIN: next_rdata = pin_s2[p]; // R4
            GPE_OFS_SET: next_rdata = lat[p]; // R4
            default: next_rdata = GPE_RD_NONE;
          endcase
        end
      end
      for (int p = 0; p < GPE_LEGACY_PORTS; p++) begin
        if (page == GPE_PAGE_LEGACY && l_idx == p[1:0]) begin
          case (l_reg)
            GPE_LOFS_PIN: next_rdata = pin_s2[p]; // R12
            GPE_LOFS_SET: next_rdata = lat[p]; // R12
            GPE_LOFS_DIR: next_rdata = dir[p]; // R12
            default: next_rdata = GPE_RD_NONE;
          endcase
        end
      end
      for (int k = 0; k < GPE_EDGE_BANKS; k++) begin
        if (page == GPE_PAGE_EDGE && e_idx == k[1:0]) begin
          case (p_reg)
            GPE_EOFS_RISE: next_rdata = rise_en[k];
            GPE_EOFS_FALL: next_rdata = fall_en[k];
            GPE_EOFS_STAT: next_rdata = pend[k];
            GPE_EOFS_MASK: next_rdata = imask[k];
            default: next_rdata = GPE_RD_NONE;
          endcase
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      bus_rdata <= GPE_RD_NONE;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // Pin drive; a pin handed to a peripheral is released by this block
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pin_out[p] = lat[p]; // R1
      pin_oe[p] = dir[p] & ~periph_sel[p]; // R1 R2
    end
  end

  // Shared request: pending unmasked edges or the external line
  assign irq = (|(pend[0] & imask[0])) | (|(pend[1] & imask[1])) | ext_s2; // R13 R14

  // Raw-pin compare keeps wake alive with the clock stopped; the flops catch up later
  gpe_word_t [GPE_EDGE_BANKS-1:0] raw_pin, raw_ev;
  assign raw_pin[0] = pin_in[GPE_EDGE_FIRST_PORT];
  assign raw_pin[1] = pin_in[GPE_EDGE_SECOND_PORT];
  always_comb begin
    for (int k = 0; k < GPE_EDGE_BANKS; k++) begin
      raw_ev[k] = (rise_en[k] & raw_pin[k] & ~edge_pin[k])
                | (fall_en[k] & ~raw_pin[k] & edge_pin[k]); // R9
    end
  end
  assign wake_req = (|pend[0]) | (|pend[1]) | (|raw_ev[0]) | (|raw_ev[1]); // R10

  // Assertions
  logic wr_full;
  assign wr_full = bus_wr && bus_be == 4'hF;

  property p_reset_inputs;
    @(posedge clk) $rose(rst_n_sync) |-> pin_oe == '0;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) // R11
    else $error("pins not inputs after reset");
  property p_oe_follows_dir;
    @(posedge clk) disable iff (!rst_n_sync)
      pin_oe[1] == (dir[1] & ~periph_sel[1]);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) // R2
    else $error("output enable does not follow direction");
  property p_set_drives_high;
    @(posedge clk) disable iff (!rst_n_sync)
      (wr_full && bus_addr == {GPE_PAGE_PORT, 3'h0, GPE_OFS_SET})
      |=> ((pin_out[0] & $past(bus_wdata & ~msk[0])) == $past(bus_wdata & ~msk[0]));
  endproperty
  a_set_drives_high: assert property (p_set_drives_high) // R3
    else $error("set write did not drive pins high");
  property p_clr_drives_low;
    @(posedge clk) disable iff (!rst_n_sync)
      (wr_full && bus_addr == {GPE_PAGE_PORT, 3'h0, GPE_OFS_CLR})
      |=> ((pin_out[0] & $past(bus_wdata & ~msk[0])) == '0);
  endproperty
  a_clr_drives_low: assert property (p_clr_drives_low) // R3
    else $error("clear write did not drive pins low");
  property p_masked_write;
    @(posedge clk) disable iff (!rst_n_sync)
      (wr_full && bus_addr == {GPE_PAGE_PORT, 3'h2, GPE_OFS_PIN})
      |=> lat[2] == (($past(lat[2]) & $past(msk[2])) | ($past(bus_wdata) & ~$past(msk[2])));
  endproperty
  a_masked_write: assert property (p_masked_write) // R5
    else $error("masked port write changed masked bits");
  property p_byte_lane;
    @(posedge clk) disable iff (!rst_n_sync)
      (bus_wr && bus_be == 4'h1 && bus_addr == {GPE_PAGE_PORT, 3'h1, GPE_OFS_DIR})
      |=> dir[1][31:8] == $past(dir[1][31:8]);
  endproperty
  a_byte_lane: assert property (p_byte_lane) // R6
    else $error("byte write touched other lanes");
  property p_pin_read;
    @(posedge clk) disable iff (!rst_n_sync)
      (bus_rd && bus_addr == {GPE_PAGE_PORT, 3'h0, GPE_OFS_PIN}) |=> bus_rdata == $past(pin_s2[0]);
  endproperty
  a_pin_read: assert property (p_pin_read) // R4
    else $error("pin read returned wrong level");
  property p_legacy_set;
    @(posedge clk) disable iff (!rst_n_sync)
      (wr_full && bus_addr == {GPE_PAGE_LEGACY, 2'h0, 2'h1, GPE_LOFS_SET})
      |=> ((pin_out[1] & $past(bus_wdata)) == $past(bus_wdata));
  endproperty
  a_legacy_set: assert property (p_legacy_set) // R12
    else $error("legacy set did not reach latch");
  property p_rise_pending;
    @(posedge clk) disable iff (!rst_n_sync)
      (rise_en[0][0] && pin_s2[0][0] && !pin_prev[0][0])
      |=> pend[0][0] ##1 (pend[0][0] || $past(bus_wr));
  endproperty
  a_rise_pending: assert property (p_rise_pending) // R8 R14
    else $error("rising edge did not set pending bit");
  property p_irq_merge;
    @(posedge clk) disable iff (!rst_n_sync)
      (ext_s2 || (|(pend[0] & imask[0])) || (|(pend[1] & imask[1])))
      |-> irq && (wake_req || ext_s2);
  endproperty
  a_irq_merge: assert property (p_irq_merge) // R13
    else $error("merged request missing");
  c_set_then_clear: cover property (@(posedge clk) disable iff (!rst_n_sync)
    (bus_wr && p_reg == GPE_OFS_SET) ##1 (bus_wr && p_reg == GPE_OFS_CLR));
  c_edge_irq: cover property (@(posedge clk) disable iff (!rst_n_sync) $rose(irq));
  c_wake_raw: cover property (@(posedge clk) disable iff (!rst_n_sync) |raw_ev[1]);
endmodule // gpe_top

// ===== tb/gpe_pins_model.sv
// Pin model: outside circuitry sharing the block's pads
`timescale 1ns/10ps
module gpe_pins_model #(
  parameter int NP = 3
) (
  input wire logic [NP-1:0][31:0] pin_out,
  input wire logic [NP-1:0][31:0] pin_oe,
  input wire logic [NP-1:0][31:0] ext_level,
  output logic [NP-1:0][31:0] pin_in
);
  // Pad follows the block where it drives, else the outside source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpe_pins_model

// ===== tb/tb_gpe_top.sv
// Self-checking bench for the edge-wake GPIO block
`timescale 1ns/10ps
module tb_gpe_top;
  import gpe_pkg::*;
  localparam int NP = 3;
  logic clk;
  logic reset_n;
  logic bus_wr;
  logic bus_rd;
  logic xirq;
  logic irq;
  logic wake_req;
  logic [GPE_AW-1:0] bus_addr;
  logic [GPE_DW-1:0] bus_wdata, bus_rdata, rv, lat, dv, m, w;
  logic [3:0] bus_be;
  logic [NP-1:0][GPE_DW-1:0] pin_in, pin_out, pin_oe, psel, ext;
  logic [11:0] b;
  logic e;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;

  gpe_top #(.NP(NP)) gpe_top_i (
    .clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_be(bus_be), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_sel(psel),
    .fourth_external_irq_line(xirq), .irq(irq), .wake_req(wake_req)
  );
  gpe_pins_model #(.NP(NP)) gpe_pins_model_i (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in)
  );

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns once the write has landed in the registers
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= be;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask

  // Data is only valid in the cycle after the strobe is taken
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // Level seen at a pad given the block's drive
  function automatic logic [31:0] pad(input logic [31:0] oe, input logic [31:0] o,
                                      input logic [31:0] x);
    return (oe & o) | (~oe & x);
  endfunction

  initial begin
    void'($urandom(32'h531c));
    reset_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = '0;
    bus_wdata = '0;
    bus_be = 4'hF;
    xirq = 1'b0;
    for (int n = 0; n < NP; n++) begin
      psel[n] = $urandom();
      ext[n] = $urandom();
    end
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset state: all pins inputs
    for (int n = 0; n < NP; n++) begin
      rd(12'(n * 32), rv);
      chk(rv, 32'h0);
      chk(pin_oe[n], 32'h0);
    end
    $display("test reset done");
    // Per-port direction, set, clear, mask and lane writes
    for (int n = 0; n < NP; n++) begin
      b = 12'(n * 32);
      dv = $urandom();
      lat = $urandom();
      m = $urandom();
      w = $urandom();
      wr(b, dv, 4'hF);
      wr(b + 12'h004, 32'h0, 4'hF);
      wr(b + 12'h008, lat, 4'hF);
      rd(b + 12'h00C, rv);
      chk(rv, lat);
      wr(b + 12'h00C, w, 4'hF);
      wr(b + 12'h010, m, 4'hF);
      lat = (lat | w) & ~m;
      rd(b + 12'h00C, rv);
      chk(rv, lat);
      chk(pin_oe[n], dv & ~psel[n]);
      w = $urandom();
      wr(b + 12'h004, m, 4'hF);
      wr(b + 12'h008, w, 4'hF);
      lat = (lat & m) | (w & ~m);
      chk(pin_out[n], lat);
      wr(b + 12'h00C, 32'hFFFF_FFFF, 4'h4);
      lat = lat | (32'h00FF_0000 & ~m);
      rd(b + 12'h00C, rv);
      chk(rv, lat);
      repeat (3) @(posedge clk);
      rd(b + 12'h008, rv);
      chk(rv, pad(dv & ~psel[n], lat, ext[n]));
      wr(b, ~dv, 4'h1);
      rd(b, rv);
      chk(rv, {dv[31:8], ~dv[7:0]});
      dv = ~dv;
      wr(b, dv, 4'hF);
      rd(b, rv);
      chk(rv, dv);
      wr(b + 12'h004, 32'h0, 4'hF);
    end
    $display("test port registers done");
    // Legacy copies ignore the mask
    for (int n = 0; n < 2; n++) begin
      b = 12'h100 + 12'(n * 16);
      dv = $urandom();
      w = $urandom();
      wr(b + 12'h008, dv, 4'hF);
      rd(12'(n * 32), rv);
      chk(rv, dv);
      wr(12'(n * 32) + 12'h004, $urandom(), 4'hF);
      wr(b, w, 4'hF);
      rd(b + 12'h004, rv);
      chk(rv, w);
      wr(b + 12'h004, dv, 4'hF);
      wr(b + 12'h00C, w, 4'hF);
      rd(b + 12'h004, rv);
      chk(rv, dv & ~w);
      wr(12'(n * 32) + 12'h004, 32'h0, 4'hF);
      wr(b + 12'h008, 32'h0, 4'hF);
    end
    rd(12'hF00, rv);
    chk(rv, 32'h0);
    wr(12'h040, 32'h0, 4'hF);
    $display("test legacy done");
    // Edge modes on first_port bit 0: rise, fall, both
    @(posedge clk);
    ext[0][0] <= 1'b0;
    repeat (5) @(posedge clk);
    wr(12'h20C, 32'h1, 4'hF);
    for (int md = 1; md < 4; md++) begin
      wr(12'h200, {31'h0, md[0]}, 4'hF);
      wr(12'h204, {31'h0, md[1]}, 4'hF);
      for (int t = 1; t >= 0; t--) begin
        @(posedge clk);
        ext[0][0] <= t[0];
        repeat (5) @(posedge clk);
        e = t[0] ? md[0] : md[1];
        rd(12'h208, rv);
        chk(rv, {31'h0, e});
        chk({31'h0, irq}, {31'h0, e});
        chk({31'h0, wake_req}, {31'h0, e});
        wr(12'h208, 32'h1, 4'hF);
        rd(12'h208, rv);
        chk(rv, 32'h0);
      end
    end
    $display("test edge modes done");
    // Third port falling edge, masked from irq but still waking
    @(posedge clk);
    ext[2][5] <= 1'b1;
    repeat (5) @(posedge clk);
    wr(12'h224, 32'h20, 4'hF);
    @(posedge clk);
    ext[2][5] <= 1'b0;
    // Raw compare must flag the edge before the synchronisers see it
    #1;
    chk({31'h0, wake_req}, 32'h1);
    repeat (5) @(posedge clk);
    rd(12'h228, rv);
    chk(rv, 32'h20);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, wake_req}, 32'h1);
    wr(12'h22C, 32'h20, 4'hF);
    chk({31'h0, irq}, 32'h1);
    wr(12'h228, 32'h20, 4'hF);
    chk({31'h0, irq}, 32'h0);
    // Shared request with the external line
    @(posedge clk);
    xirq <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    xirq <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupts done");
    give_verdict();
  end
endmodule // tb_gpe_top
